/* File: dv/serial_peer.sv */
// Behavioural remote controller on the command link of the switch.
// Assumes the bench clock; the peer drives the device receive line.
`timescale 1ns/1ps
module serial_peer
   import switch_ctrl_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic line_in, // Device transmit line
   output logic line_out, // Device receive line
   output logic [7:0] got, // Last byte heard
   output int got_n // Bytes heard
);
   initial line_out = LINE_IDLE;
   initial got_n = 0;
   // Same bit time as the device
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {LINE_STOP, b, LINE_START};
      for (int i = 0; i < 10; i++) begin
         line_out = f[i];
         repeat (BIT_CYCLES_INT) @(posedge clk);
         #1;
      end
   endtask : send
   // No handshake: the peer never waits for the device
   always begin
      @(negedge line_in);
      repeat (BIT_CYCLES_INT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT_CYCLES_INT) @(posedge clk);
         got[i] = line_in;
      end
      repeat (BIT_CYCLES_INT) @(posedge clk);
      got_n++;
   end
endmodule : serial_peer

/* File: dv/serial_port_switch_control_assertions.sv */
// Port-level checks for the channel-select command interpreter.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
module serial_port_switch_control_assertions
   import switch_ctrl_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic rst_b, // Reset, active low
   input wire logic rx_pin, // Receive line
   input wire logic tx_pin, // Transmit line
   input wire logic sync_mode, // Sync units mode
   input wire logic wide_variant, // Sixteen ports
   input wire logic host_sel_valid, // Local request
   input wire logic [4:0] host_sel_level1, // Top port
   input wire logic [4:0] host_sel_level2, // Lower port
   input wire logic [15:0] switch_attached, // Lower switches
   input wire logic add_accept, // Accept offer
   input wire logic add_decline, // Decline offer
   input wire logic [4:0] channel, // Channel
   input wire logic [4:0] sub_channel, // Lower channel
   input wire logic video_off, // Blanked
   input wire logic offer_pending, // Offer open
   input wire logic [3:0] offer_port, // Offered port
   input wire logic [15:0] cascade_ports // Added switches
);
   typedef struct packed {logic [12:0] low; logic [12:0] quiet;} watch_t;
   watch_t w_reg, w_next;
   wire legal = host_sel_level1 <= (wide_variant ? PORTS_LARGE : PORTS_SMALL)
      && host_sel_level2 <= PORTS_LARGE
      && (host_sel_level2 == CHAN_OFF || host_sel_level1 != CHAN_OFF);
   // Low-run length of the line and time spent out of sync mode
   always_comb begin
      w_next = w_reg;
      w_next.low = tx_pin ? 13'h0000 : w_reg.low + 13'h0001;
      if (sync_mode) w_next.quiet = 13'h0000;
      else if (w_reg.quiet != 13'h1fff) w_next.quiet = w_reg.quiet + 13'h0001;
      if (!rst_b) w_next = '0;
   end
   always_ff @(posedge clk) w_reg <= w_next;
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   a_video_tracks: assert property (video_off == (channel == CHAN_OFF))
      else $error("video_off disagrees with channel");
   a_reset_clears: assert property (disable iff (1'b0) !rst_b |=> channel == CHAN_OFF
      && video_off && tx_pin && !offer_pending && cascade_ports == MASK_NONE)
      else $error("reset values wrong");
   a_sub_needs_chan: assert property (channel == CHAN_OFF |-> sub_channel == CHAN_OFF)
      else $error("sub channel set with video off");
   a_local_pick: assert property (host_sel_valid && !sync_mode && legal |=>
      channel == $past(host_sel_level1) && sub_channel == $past(host_sel_level2))
      else $error("local selection not taken");
   // Every low stretch is whole bit times
   a_bit_time: assert property ($rose(tx_pin) |-> w_reg.low % 13'h0209 == 13'h0000)
      else $error("transmit bit time wrong");
   a_quiet_unsynced: assert property (w_reg.quiet > 13'h1518 |-> tx_pin)
      else $error("transmit outside sync mode");
   a_accept_adds: assert property (offer_pending && add_accept |=>
      !offer_pending && cascade_ports[$past(offer_port)])
      else $error("accepted switch not added");
   a_decline_no_add: assert property (offer_pending && add_decline && !add_accept |=>
      !offer_pending && (cascade_ports & ~$past(cascade_ports)) == MASK_NONE)
      else $error("declined switch added");
   a_chan_holds: assert property (!sync_mode && !$past(sync_mode) && !host_sel_valid
      |=> $stable(channel))
      else $error("channel moved without request");
   cover property ($rose(tx_pin));
   cover property (offer_pending && add_accept);
   cover property (host_sel_valid && legal);
endmodule : serial_port_switch_control_assertions
bind serial_port_switch_control serial_port_switch_control_assertions
   serial_port_switch_control_assertions_inst (.clk(clk), .rst_b(rst_b), .rx_pin(rx_pin),
   .tx_pin(tx_pin), .sync_mode(sync_mode), .wide_variant(wide_variant),
   .host_sel_valid(host_sel_valid), .host_sel_level1(host_sel_level1),
   .host_sel_level2(host_sel_level2), .switch_attached(switch_attached),
   .add_accept(add_accept), .add_decline(add_decline), .channel(channel),
   .sub_channel(sub_channel), .video_off(video_off), .offer_pending(offer_pending),
   .offer_port(offer_port), .cascade_ports(cascade_ports));

/* File: dv/serial_port_switch_control_tb.sv */
// Self-checking bench for the channel-select command interpreter.
// Assumes serial_peer on the command link and the bound checker.
`timescale 1ns/1ps
module serial_port_switch_control_tb
   import switch_ctrl_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic sync_mode = 1'b1;
   logic wide_variant = 1'b1;
   logic host_sel_valid = 1'b0;
   logic [4:0] host_sel_level1 = 5'h00;
   logic [4:0] host_sel_level2 = 5'h00;
   logic [15:0] switch_attached = 16'h0000;
   logic add_accept = 1'b0;
   logic add_decline = 1'b0;
   logic rx_pin, tx_pin, video_off, offer_pending;
   logic [4:0] channel, sub_channel;
   logic [3:0] offer_port;
   logic [15:0] cascade_ports;
   logic [7:0] got;
   int got_n;
   int num_errors = 0;
   int num_checks = 0;
   int cycles = 0;
   initial forever #50 clk = ~clk;
   serial_port_switch_control serial_port_switch_control_inst (.clk(clk), .rst_b(rst_b),
      .rx_pin(rx_pin), .tx_pin(tx_pin), .sync_mode(sync_mode), .wide_variant(wide_variant),
      .host_sel_valid(host_sel_valid), .host_sel_level1(host_sel_level1),
      .host_sel_level2(host_sel_level2), .switch_attached(switch_attached),
      .add_accept(add_accept), .add_decline(add_decline), .channel(channel),
      .sub_channel(sub_channel), .video_off(video_off), .offer_pending(offer_pending),
      .offer_port(offer_port), .cascade_ports(cascade_ports));
   serial_peer serial_peer_inst (.clk(clk), .line_in(tx_pin), .line_out(rx_pin),
      .got(got), .got_n(got_n));
   task automatic results;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : results
   task automatic check(input logic [15:0] act, input logic [15:0] exp);
      num_checks++;
      if (act !== exp) begin
         num_errors++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, act, exp);
      end
   endtask : check
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // Wait for an echo, or a whole frame time when none is due
   task automatic hear(input int n, input logic echo, input logic [7:0] b);
      for (int i = 0; i < 6000 && got_n == n; i++) @(posedge clk);
      #1;
      check(16'(got_n - n), 16'(echo));
      if (echo) check(16'(got), 16'(b));
   endtask : hear
   task automatic serial(input logic [7:0] b, input logic [4:0] ch, input logic echo);
      int n;
      n = got_n;
      serial_peer_inst.send(b);
      hear(n, echo, b);
      check(16'(channel), 16'(ch));
      check(16'(video_off), 16'(ch == CHAN_OFF));
   endtask : serial
   task automatic pick(input logic [4:0] a, input logic [4:0] s);
      host_sel_level1 = a;
      host_sel_level2 = s;
      host_sel_valid = 1'b1;
      step(1);
      host_sel_valid = 1'b0;
      step(1);
   endtask : pick
   task automatic test_reset;
      rst_b = 1'b0;
      step(3);
      rst_b = 1'b1;
      step(1);
      check(16'(channel), 16'(CHAN_OFF));
      check(16'(video_off), 16'h0001);
      check(16'(tx_pin), 16'(LINE_IDLE));
      check(cascade_ports, MASK_NONE);
      check(16'(offer_pending), 16'h0000);
      $display("test_reset done");
   endtask : test_reset
   task automatic test_serial;
      serial(8'h12, 5'h03, 1'b1);
      serial(8'h71, CHAN_OFF, 1'b1);
      serial(8'h20, CHAN_OFF, 1'b0);
      serial(8'h1f, 5'h10, 1'b1);
      $display("test_serial done");
   endtask : test_serial
   task automatic test_narrow;
      wide_variant = 1'b0;
      serial(8'h18, 5'h10, 1'b0);
      $display("test_narrow done");
   endtask : test_narrow
   task automatic test_local;
      int n;
      n = got_n;
      pick(5'h05, 5'h03);
      check(16'(channel), 16'h0005);
      check(16'(sub_channel), 16'h0003);
      hear(n, 1'b1, CMD_BASE + 8'h04);
      pick(CHAN_OFF, 5'h02);
      check(16'(channel), 16'h0005);
      n = got_n;
      pick(CHAN_OFF, CHAN_OFF);
      hear(n, 1'b1, CMD_VIDEO_OFF);
      wide_variant = 1'b1;
      $display("test_local done");
   endtask : test_local
   task automatic test_sync_off;
      sync_mode = 1'b0;
      serial(8'h11, CHAN_OFF, 1'b0);
      pick(5'h02, CHAN_OFF);
      check(16'(channel), 16'h0002);
      sync_mode = 1'b1;
      $display("test_sync_off done");
   endtask : test_sync_off
   task automatic test_discovery;
      switch_attached = 16'h0004;
      step(4);
      check(16'(offer_pending), 16'h0001);
      check(16'(offer_port), 16'h0002);
      add_accept = 1'b1;
      step(1);
      add_accept = 1'b0;
      step(1);
      check(cascade_ports, 16'h0004);
      switch_attached = 16'h0024;
      step(4);
      check(16'(offer_port), 16'h0005);
      add_decline = 1'b1;
      step(1);
      add_decline = 1'b0;
      step(1);
      check(16'(offer_pending), 16'h0000);
      check(cascade_ports, 16'h0004);
      $display("test_discovery done");
   endtask : test_discovery
   // Ceiling sits above the roughly 73k cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 90000) begin
         num_errors++;
         results();
      end
   end
   initial begin
      test_reset();
      test_serial();
      test_narrow();
      test_local();
      test_sync_off();
      test_discovery();
      test_reset();
      results();
   end
endmodule : serial_port_switch_control_tb

/* File: src/serial_link.sv */
// 8N1 asynchronous transmitter and receiver at the fixed command baud rate.
// Assumes rx_in is already synchronised to clk by the caller.
`timescale 1ns/1ps
module serial_link
   import switch_ctrl_pkg::*;
(
   input wire logic clk, // System clock
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic rx_in, // Synchronised receive line
   output logic [7:0] rx_data, // Last received byte
   output logic rx_valid, // One-cycle pulse per good frame
   input wire logic [7:0] tx_data, // Byte to send
   input wire logic tx_start, // Take tx_data when not busy
   output logic tx_busy, // Transmitter occupied
   output logic tx_out // Transmit line
);
   typedef struct packed {
      link_state_t rx_st;
      logic [9:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_shift;
      logic rx_valid;
      link_state_t tx_st;
      logic [9:0] tx_cnt;
      logic [2:0] tx_bit;
      logic [7:0] tx_shift;
      logic tx_line;
   } link_t;

   link_t s_reg;
   link_t s_next;

   always_comb begin
      s_next = s_reg;
      s_next.rx_valid = 1'b0;
      if (s_reg.rx_cnt != CNT_ZERO) begin
         s_next.rx_cnt = s_reg.rx_cnt - CNT_STEP;
      end
      // Receiver samples each bit at its middle
      unique case (s_reg.rx_st)
         LS_IDLE: begin
            if (rx_in == LINE_START) begin
               s_next.rx_st = LS_START;
               s_next.rx_cnt = HALF_BIT_CYCLES;
            end
         end
         LS_START: begin
            if (s_reg.rx_cnt == CNT_ZERO) begin
               // A glitch shorter than half a bit is dropped here
               s_next.rx_st = (rx_in == LINE_START) ? LS_DATA : LS_IDLE;
               // One count less than the bit time, matching the transmitter
               s_next.rx_cnt = BIT_CYCLES - CNT_STEP;
               s_next.rx_bit = FIRST_DATA_BIT;
            end
         end
         LS_DATA: begin
            if (s_reg.rx_cnt == CNT_ZERO) begin
               s_next.rx_shift = {rx_in, s_reg.rx_shift[7:1]};
               s_next.rx_cnt = BIT_CYCLES - CNT_STEP;
               s_next.rx_bit = s_reg.rx_bit + BIT_STEP;
               if (s_reg.rx_bit == LAST_DATA_BIT) begin
                  s_next.rx_st = LS_STOP;
               end
            end
         end
         LS_STOP: begin
            if (s_reg.rx_cnt == CNT_ZERO) begin
               // Framing errors are silently discarded
               s_next.rx_valid = (rx_in == LINE_STOP);
               s_next.rx_st = LS_IDLE;
            end
         end
      endcase

      if (s_reg.tx_cnt != CNT_ZERO) begin
         s_next.tx_cnt = s_reg.tx_cnt - CNT_STEP;
      end
      unique case (s_reg.tx_st)
         LS_IDLE: begin
            s_next.tx_line = LINE_IDLE;
            if (tx_start) begin
               s_next.tx_shift = tx_data;
               s_next.tx_line = LINE_START;
               s_next.tx_cnt = BIT_CYCLES - CNT_STEP;
               s_next.tx_st = LS_START;
            end
         end
         LS_START: begin
            if (s_reg.tx_cnt == CNT_ZERO) begin
               s_next.tx_line = s_reg.tx_shift[0];
               s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
               s_next.tx_bit = FIRST_DATA_BIT;
               s_next.tx_cnt = BIT_CYCLES - CNT_STEP;
               s_next.tx_st = LS_DATA;
            end
         end
         LS_DATA: begin
            if (s_reg.tx_cnt == CNT_ZERO) begin
               s_next.tx_cnt = BIT_CYCLES - CNT_STEP;
               s_next.tx_bit = s_reg.tx_bit + BIT_STEP;
               if (s_reg.tx_bit == LAST_DATA_BIT) begin
                  s_next.tx_line = LINE_STOP;
                  s_next.tx_st = LS_STOP;
               end else begin
                  s_next.tx_line = s_reg.tx_shift[0];
                  s_next.tx_shift = {1'b0, s_reg.tx_shift[7:1]};
               end
            end
         end
         LS_STOP: begin
            if (s_reg.tx_cnt == CNT_ZERO) begin
               s_next.tx_st = LS_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         s_reg <= '{rx_st: LS_IDLE, rx_cnt: CNT_ZERO, rx_bit: FIRST_DATA_BIT,
                    rx_shift: BYTE_ZERO, rx_valid: 1'b0, tx_st: LS_IDLE,
                    tx_cnt: CNT_ZERO, tx_bit: FIRST_DATA_BIT, tx_shift: BYTE_ZERO,
                    tx_line: LINE_IDLE};
      end else begin
         s_reg <= s_next;
      end
   end

   assign rx_data = s_reg.rx_shift;
   assign rx_valid = s_reg.rx_valid;
   assign tx_busy = (s_reg.tx_st != LS_IDLE);
   assign tx_out = s_reg.tx_line;
endmodule : serial_link

/* File: src/serial_port_switch_control.sv */
// Channel-select command interpreter for the auxiliary serial port of a console switch.
// Assumes rx_pin and switch_attached are asynchronous pins; all else is on clk.
//
// Behaviour
// - Serial link runs 8 data bits, no parity, one stop bit, 19200 baud.
// - No flow control; every valid received command byte is sent back.
// - Each received command byte chooses the host port routed to the console.
// - Bytes 10h..1Fh pick ports 1..16; byte 71h picks channel zero, video off.
// - In synchronised-units mode, any change of selected channel sends the matching command out the port.
// - A received command switches this unit to that channel, following a master.
// - Serial control acts only in synchronised-units mode; all units share one baud.
// - Cascaded hosts use two-digit port numbers per level, up to four digits.
// - At most two cascade levels, with hosts at either level.
// - Either eight or sixteen direct host ports, chosen by the variant.
// - A newly attached lower switch is offered; on acceptance its ports are added.
`timescale 1ns/1ps
module serial_port_switch_control
   import switch_ctrl_pkg::*;
(
   input wire logic clk, // System clock, 10 MHz
   input wire logic rst_b, // Synchronous reset, active low
   input wire logic rx_pin, // Auxiliary port receive line
   output logic tx_pin, // Auxiliary port transmit line
   input wire logic sync_mode, // Port set to synchronised-units mode
   input wire logic wide_variant, // High: sixteen ports, low: eight
   input wire logic host_sel_valid, // One-cycle local selection request
   input wire logic [4:0] host_sel_level1, // Top-level port, 0 is video off
   input wire logic [4:0] host_sel_level2, // Lower-switch port, 0 for none
   input wire logic [15:0] switch_attached, // Lower switch present per port
   input wire logic add_accept, // User accepts adding offered ports
   input wire logic add_decline, // User declines the offer
   output logic [4:0] channel, // Selected top-level channel
   output logic [4:0] sub_channel, // Port selected in lower switch
   output logic video_off, // Video blanked
   output logic offer_pending, // Offer to add a lower switch open
   output logic [3:0] offer_port, // Zero-based port of offered switch
   output logic [15:0] cascade_ports // Ports whose lower switch is registered
);
   typedef struct packed {
      logic rx_meta;
      logic rx_sync;
      logic [15:0] att_meta;
      logic [15:0] att_sync;
      logic [15:0] offered;
      logic [4:0] chan;
      logic [4:0] sub_chan;
      logic video_off;
      logic [7:0] tx_byte;
      logic tx_pend;
      logic offer_pend;
      logic [3:0] offer_port;
      logic [15:0] added;
   } ctrl_t;

   ctrl_t s_reg;
   ctrl_t s_next;
   logic [7:0] rx_data;
   logic rx_valid;
   logic tx_busy;
   logic tx_out;
   logic tx_start;

   serial_link link (
      .clk(clk),
      .rst_b(rst_b),
      .rx_in(s_reg.rx_sync),
      .rx_data(rx_data),
      .rx_valid(rx_valid),
      .tx_data(s_reg.tx_byte),
      .tx_start(tx_start),
      .tx_busy(tx_busy),
      .tx_out(tx_out)
   );

   // Pending byte is handed over as soon as the transmitter is free
   // Outside synchronised-units mode nothing new starts; a frame under way still finishes
   assign tx_start = s_reg.tx_pend && !tx_busy && sync_mode;

   function automatic logic [7:0] chan_cmd(input logic [4:0] ch);
      logic [4:0] idx;
      idx = ch - CHAN_STEP;
      chan_cmd = (ch == CHAN_OFF) ? CMD_VIDEO_OFF : {CMD_BASE[7:4], idx[3:0]};
   endfunction : chan_cmd

   logic [4:0] port_count;
   logic [15:0] port_mask;
   logic rx_is_port;
   logic rx_cmd_ok;
   logic [4:0] rx_chan;
   logic [15:0] new_att;
   logic found;
   logic [3:0] first_new;
   logic [4:0] want_chan;
   logic want_change;
   logic local_ok;

   // Decode is kept apart from the state update; the next-state block reads settled terms
   always_comb begin
      port_count = wide_variant ? PORTS_LARGE : PORTS_SMALL;
      port_mask = wide_variant ? MASK_LARGE : MASK_SMALL;

      // Decode a received byte into a channel
      rx_is_port = (rx_data >= CMD_BASE) && (rx_data <= CMD_LAST);
      rx_chan = {1'b0, rx_data[3:0]} + CHAN_STEP;
      rx_cmd_ok = rx_valid && sync_mode &&
                  ((rx_is_port && (rx_chan <= port_count)) || (rx_data == CMD_VIDEO_OFF));
      if (rx_data == CMD_VIDEO_OFF) begin
         rx_chan = CHAN_OFF;
      end

      // Local request: level-1 port within variant, level-2 (up to 16) only with a level-1 port chosen
      local_ok = host_sel_valid && (host_sel_level1 <= port_count) &&
                 ((host_sel_level2 == CHAN_OFF) ||
                  ((host_sel_level1 != CHAN_OFF) && (host_sel_level2 <= PORTS_LARGE)));
   end

   // Per-port candidates; each port looks only at the ports below it, so offers go lowest first
   logic [15:0] new_below;
   logic [15:0] new_first;
   generate
      for (genvar p = 0; p < MAX_PORTS; p++) begin : g_port
         assign new_att[p] = s_reg.att_sync[p] && !s_reg.offered[p] && !s_reg.added[p] &&
                             port_mask[p];
         if (p == 0) begin : g_lowest
            assign new_below[p] = 1'b0;
         end else begin : g_higher
            assign new_below[p] = |new_att[p - 1:0];
         end
         assign new_first[p] = new_att[p] && !new_below[p];
      end
   endgenerate
   assign found = |new_att;

   always_comb begin
      s_next = s_reg;
      s_next.rx_meta = rx_pin;
      s_next.rx_sync = s_reg.rx_meta;
      s_next.att_meta = switch_attached;
      s_next.att_sync = s_reg.att_meta;

      want_chan = s_reg.chan;
      want_change = 1'b0;
      if (rx_cmd_ok) begin
         // A serial command names only the top level
         want_chan = rx_chan;
         s_next.sub_chan = CHAN_OFF;
         // One byte serves both as echo and as the follow command
         s_next.tx_byte = rx_data;
         s_next.tx_pend = 1'b1;
      end else if (local_ok) begin
         want_chan = host_sel_level1;
         s_next.sub_chan = (host_sel_level1 == CHAN_OFF) ? CHAN_OFF : host_sel_level2;
         want_change = (host_sel_level1 != s_reg.chan);
      end
      // Anything else received falls through untouched
      s_next.chan = want_chan;
      s_next.video_off = (want_chan == CHAN_OFF);
      if (want_change && sync_mode) begin
         s_next.tx_byte = chan_cmd(want_chan);
         s_next.tx_pend = 1'b1;
      end else if (tx_start && !rx_cmd_ok) begin
         s_next.tx_pend = 1'b0;
      end
      // A byte still pending when the mode drops would otherwise go out long after
      if (!sync_mode) begin
         s_next.tx_pend = 1'b0;
      end

      // Lower-switch discovery: offer each new attachment once, lowest port first
      first_new = PORT_IDX_ZERO;
      // At most one bit of new_first is set, so or-ing the indices encodes it
      for (int i = 0; i < MAX_PORTS; i++) begin
         if (new_first[i]) begin
            first_new = first_new | 4'(i);
         end
      end
      // Detaching clears history so a later reconnection is offered again
      s_next.offered = s_reg.offered & s_reg.att_sync;
      s_next.added = s_reg.added & s_reg.att_sync;
      if (s_reg.offer_pend) begin
         if (add_accept) begin
            s_next.added = (s_reg.added | (BIT_ONE << s_reg.offer_port)) & s_reg.att_sync;
            s_next.offer_pend = 1'b0;
         end else if (add_decline || !s_reg.att_sync[s_reg.offer_port]) begin
            s_next.offer_pend = 1'b0;
         end
      end else if (found) begin
         s_next.offer_pend = 1'b1;
         s_next.offer_port = first_new;
         s_next.offered = (s_reg.offered | (BIT_ONE << first_new)) & s_reg.att_sync;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_b) begin
         // Synchroniser stages start at the idle level so that no false start bit follows reset
         s_reg <= '{
            rx_meta: LINE_IDLE,
            rx_sync: LINE_IDLE,
            att_meta: MASK_NONE,
            att_sync: MASK_NONE,
            offered: MASK_NONE,
            chan: CHAN_OFF,
            sub_chan: CHAN_OFF,
            video_off: 1'b1,
            tx_byte: BYTE_ZERO,
            tx_pend: 1'b0,
            offer_pend: 1'b0,
            offer_port: PORT_IDX_ZERO,
            added: MASK_NONE
         };
      end else begin
         s_reg <= s_next;
      end
   end

   assign tx_pin = tx_out;
   assign channel = s_reg.chan;
   assign sub_channel = s_reg.sub_chan;
   assign video_off = s_reg.video_off;
   assign offer_pending = s_reg.offer_pend;
   assign offer_port = s_reg.offer_port;
   assign cascade_ports = s_reg.added;
endmodule : serial_port_switch_control

/* File: src/switch_ctrl_pkg.sv */
// Constants shared by the channel-select command interpreter and its serial link.
// Assumes a single 10 MHz system clock.
package switch_ctrl_pkg;
   localparam int unsigned CLK_HZ = 10000000;
   localparam int unsigned BAUD_BPS = 19200;
   // Nearest whole cycle count per bit: 521 cycles, about 0.03 percent slow
   localparam int unsigned BIT_CYCLES_INT = (CLK_HZ + BAUD_BPS / 2) / BAUD_BPS;
   localparam logic [9:0] BIT_CYCLES = 10'(BIT_CYCLES_INT);
   localparam logic [9:0] HALF_BIT_CYCLES = 10'(BIT_CYCLES_INT / 2);
   localparam logic [9:0] CNT_ZERO = 10'h000;
   localparam logic [9:0] CNT_STEP = 10'h001;
   localparam int unsigned DATA_BITS = 8;
   localparam logic [2:0] LAST_DATA_BIT = 3'(DATA_BITS - 1);
   localparam logic [2:0] FIRST_DATA_BIT = 3'h0;
   localparam logic [2:0] BIT_STEP = 3'h1;
   localparam logic LINE_IDLE = 1'b1;
   localparam logic LINE_START = 1'b0;
   localparam logic LINE_STOP = 1'b1;
   // Command codes
   localparam logic [7:0] CMD_BASE = 8'h10;
   localparam logic [7:0] CMD_LAST = 8'h1f;
   localparam logic [7:0] CMD_VIDEO_OFF = 8'h71;
   // Channels: 0 is video off, 1..16 are host ports
   localparam int unsigned MAX_PORTS = 16;
   localparam logic [4:0] CHAN_OFF = 5'h00;
   localparam logic [4:0] CHAN_STEP = 5'h01;
   localparam logic [4:0] PORTS_SMALL = 5'h08;
   localparam logic [4:0] PORTS_LARGE = 5'h10;
   localparam logic [3:0] PORT_IDX_ZERO = 4'h0;
   localparam logic [15:0] MASK_NONE = 16'h0000;
   localparam logic [15:0] MASK_SMALL = 16'h00ff;
   localparam logic [15:0] MASK_LARGE = 16'hffff;
   localparam logic [15:0] BIT_ONE = 16'h0001;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef enum logic [1:0] {
      LS_IDLE = 2'b00,
      LS_START = 2'b01,
      LS_DATA = 2'b10,
      LS_STOP = 2'b11
   } link_state_t;
endpackage : switch_ctrl_pkg
